// File: hw/freq_pull_ctrl.sv
// Register bank and apply sequencer for the digital frequency pull control
`timescale 1ns/10ps
module freq_pull_ctrl
    import pull_ctrl_pkg::*;
#(
    parameter logic [RANGE_W-1:0] FACTORY_RANGE_CODE = FACTORY_RANGE
)(
    input  wire logic                 clk_sys,
    input  wire logic                 nrst,
    input  wire logic [ADDR_W-1:0]    reg_addr,
    input  wire logic [DATA_W-1:0]    reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic [DATA_W-1:0]         reg_rdata,
    input  wire logic                 oe_pin,
    input  wire logic                 sw_oe_strap,
    output logic [FCW_W-1:0]          fcw_applied,
    output logic [RANGE_W-1:0]        range_applied,
    output logic signed [OFFSET_W-1:0] frac_offset,
    output logic                      freq_update,
    output logic                      update_busy,
    output logic                      out_enable
);
    // ****************************************
    // Registers and wires
    // ****************************************
    logic [LOW_W-1:0]       freq_low_reg;
    logic [HIGH_W-1:0]      freq_high_reg;
    logic                   oe_bit_reg;
    logic [RANGE_W-1:0]     range_reg;
    logic                   sw_oe_mode_reg;
    logic [1:0]             strap_cnt_reg;
    logic                   strap_done_reg;
    apply_state_e           st_reg;
    apply_state_e           st_next;
    logic [GAP_CNT_W-1:0]   gap_cnt_reg;
    logic                   pending_reg;
    logic                   pending_next;
    logic                   oe_pin_sync;
    logic                   strap_sync;
    logic                   wr_low;
    logic                   wr_high;
    logic                   wr_range;
    logic                   gap_done;
    logic [FCW_W-1:0]       fcw_limited;
    logic signed [OFFSET_W-1:0] offset_comb;

    assign wr_low   = reg_wr && (reg_addr == REG_FREQ_LOW);
    assign wr_high  = reg_wr && (reg_addr == REG_FREQ_HIGH);
    assign wr_range = reg_wr && (reg_addr == REG_PULL_RANGE);
    assign gap_done = (gap_cnt_reg >= GAP_CNT_W'(UPDATE_GAP_CYC - 1));

    // ****************************************
    // Pin synchronisers
    // ****************************************
    bit_sync u_oe_sync (
        .clk_sys  (clk_sys),
        .nrst     (nrst),
        .async_in (oe_pin),
        .sync_out (oe_pin_sync)
    );

    bit_sync u_strap_sync (
        .clk_sys  (clk_sys),
        .nrst     (nrst),
        .async_in (sw_oe_strap),
        .sync_out (strap_sync)
    );

    // ****************************************
    // Output-enable mode strap
    // ****************************************
    // Strap is taken once the synchroniser has settled after release
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            strap_cnt_reg  <= 2'h0;
            strap_done_reg <= 1'b0;
            sw_oe_mode_reg <= 1'b0;
        end else if (!strap_done_reg) begin
            strap_cnt_reg <= strap_cnt_reg + 2'h1;
            if (strap_cnt_reg == STRAP_WAIT) begin
                strap_done_reg <= 1'b1;
                sw_oe_mode_reg <= strap_sync;
            end
        end
    end

    // ****************************************
    // Frequency word registers
    // ****************************************
    // RULE6: low word from register zero
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            freq_low_reg <= FREQ_LOW_RST;
        end else if (wr_low) begin
            freq_low_reg <= reg_wdata[LOW_W-1:0];
        end
    end

    // RULE6: upper bits from register one
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            freq_high_reg <= FREQ_HIGH_RST;
        end else if (wr_high) begin
            freq_high_reg <= reg_wdata[HIGH_W-1:0];
        end
    end

    // RULE13: bit writable only under software control
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            oe_bit_reg <= OE_BIT_RST;
        end else if (wr_high && sw_oe_mode_reg) begin
            oe_bit_reg <= reg_wdata[OE_BIT];
        end
    end

    // ****************************************
    // Pull range register
    // ****************************************
    // RULE2: four-bit range select
    // RULE3: factory range after power-up
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            range_reg <= FACTORY_RANGE_CODE;
        end else if (wr_range) begin
            range_reg <= reg_wdata[RANGE_W-1:0];
        end
    end

    // ****************************************
    // Read port
    // ****************************************
    // Unmapped addresses read zero; data appears one cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                REG_FREQ_LOW:   reg_rdata <= freq_low_reg;
                REG_FREQ_HIGH:  reg_rdata <= {5'h00, oe_bit_reg, freq_high_reg};
                REG_PULL_RANGE: reg_rdata <= {12'h000, range_reg};
                default:        reg_rdata <= '0;
            endcase
        end
    end

    // ****************************************
    // Apply sequencer
    // ****************************************
    // RULE7: high word write starts the change
    // RULE12: changes spaced by the update gap
    always_comb begin
        st_next = st_reg;
        case (st_reg)
            ST_IDLE:  st_next = wr_high ? ST_APPLY : ST_IDLE;
            ST_APPLY: st_next = ST_HOLD;
            ST_HOLD: begin
                if (gap_done) begin
                    st_next = (pending_reg || wr_high) ? ST_APPLY : ST_IDLE;
                end
            end
            default:  st_next = ST_IDLE;
        endcase
    end

    // A commit seen in the clearing cycle does not set pending; the apply that is starting takes its word
    always_comb begin
        pending_next = pending_reg;
        if (st_next == ST_APPLY) begin
            pending_next = 1'b0;
        end
        if (wr_high && (st_next != ST_APPLY)) begin
            pending_next = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            st_reg      <= ST_IDLE;
            pending_reg <= 1'b0;
        end else begin
            st_reg      <= st_next;
            pending_reg <= pending_next;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            gap_cnt_reg <= '0;
        end else if (st_reg == ST_APPLY) begin
            gap_cnt_reg <= '0;
        end else if (!gap_done) begin
            gap_cnt_reg <= gap_cnt_reg + GAP_CNT_W'(1);
        end
    end

    // ****************************************
    // Applied word and divider offset
    // ****************************************
    pull_scaler u_scaler (
        .fcw         ({freq_high_reg, freq_low_reg}),
        .range_code  (range_reg),
        .fcw_limited (fcw_limited),
        .frac_offset (offset_comb)
    );

    // RULE1: only host words reach the synthesiser
    // RULE5: zero word means nominal frequency
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            fcw_applied <= '0;
            frac_offset <= '0;
            freq_update <= 1'b0;
        end else begin
            freq_update <= (st_reg == ST_APPLY);
            if (st_reg == ST_APPLY) begin
                fcw_applied <= fcw_limited;
                frac_offset <= offset_comb;
            end
        end
    end

    // Range output follows range_reg one cycle later, without waiting for an apply; frac_offset keeps the old scaling until the next apply
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            range_applied <= FACTORY_RANGE_CODE;
            update_busy   <= 1'b0;
        end else begin
            range_applied <= range_reg;
            update_busy   <= (st_next != ST_IDLE);
        end
    end

    // RULE13: pin or register picks the enable
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            out_enable <= 1'b0;
        end else begin
            out_enable <= sw_oe_mode_reg ? oe_bit_reg : oe_pin_sync;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    logic [GAP_CNT_W:0] since_upd_reg;
    logic               seen_upd_reg;
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            since_upd_reg <= '0;
            seen_upd_reg  <= 1'b0;
        end else if (freq_update) begin
            since_upd_reg <= (GAP_CNT_W+1)'(1);
            seen_upd_reg  <= 1'b1;
        end else if (since_upd_reg != '1) begin
            since_upd_reg <= since_upd_reg + (GAP_CNT_W+1)'(1);
        end
    end

    word_applied_a: assert property (  // RULE6
        (st_reg == ST_APPLY) |=> (fcw_applied == $past(fcw_limited)) && freq_update)
        else $error("applied word differs from staged registers");

    low_waits_a: assert property (  // RULE7
        (wr_low && st_reg == ST_IDLE && !wr_high) |=> ##1 $stable(fcw_applied))
        else $error("low word write changed the applied word");

    high_starts_a: assert property (  // RULE7
        (st_reg == ST_IDLE && wr_high) |=> ##1 freq_update)
        else $error("high word write did not start an update");

    update_gap_a: assert property (  // RULE12
        (freq_update && seen_upd_reg) |-> (since_upd_reg >= (GAP_CNT_W+1)'(UPDATE_GAP_CYC)))
        else $error("updates closer than the minimum gap");

    word_limit_a: assert property (  // RULE4
        fcw_applied != FCW_MOST_NEG)
        else $error("applied word outside the pull range");

    range_write_a: assert property (  // RULE2
        wr_range |=> ##1 (range_applied == $past(reg_wdata[RANGE_W-1:0], 2)))
        else $error("pull range write not applied");

    reset_nominal_a: assert property (  // RULE3
        $rose(nrst) |-> (fcw_applied == '0) && (range_applied == FACTORY_RANGE_CODE))
        else $error("power-up state not nominal");

    zero_offset_a: assert property (  // RULE9
        (st_reg == ST_APPLY && fcw_limited == '0) |=> (frac_offset == '0))
        else $error("zero word gave nonzero offset");

    pin_oe_a: assert property (  // RULE13
        (!sw_oe_mode_reg && $stable(oe_pin_sync)) |=> (out_enable == $past(oe_pin_sync)))
        else $error("pin control not followed");

    sw_oe_a: assert property (  // RULE13
        (wr_high && sw_oe_mode_reg) |=> ##1 (out_enable == $past(reg_wdata[OE_BIT], 2)))
        else $error("software enable bit not followed");
endmodule

// File: hw/pull_ctrl_pkg.sv
// Constants, register map and timing for the digital frequency pull control block
// Summary of operation
// RULE1: Output frequency set only by host-written words
// RULE2: Sixteen pull ranges picked by 4-bit field
// RULE3: Power-up nominal frequency, factory pull range
// RULE4: Shift limited to the selected pull range
// RULE5: 26-bit two's complement word, resets zero
// RULE6: Low 16 bits reg 0, upper 10 reg 1
// RULE7: Word takes effect only on high word write
// RULE8: Host computes word as scaled rounded offset
// RULE9: Offset linear in word via fractional divider
// RULE10: Step 5e-12 up to 200 ppm, coarser above
// RULE11: Host sets output enable with high word
// RULE12: Updates applied no faster than 38 kHz
// RULE13: Output-enable bit ignored under pin control
// RULE14: Codes 0-15 select ranges in ascending width
package pull_ctrl_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 16;
    localparam logic [7:0]  REG_FREQ_LOW    = 8'h00;
    localparam logic [7:0]  REG_FREQ_HIGH   = 8'h01;
    localparam logic [7:0]  REG_PULL_RANGE  = 8'h02;

    // ****************************************
    // Field layout
    // ****************************************
    localparam int          FCW_W           = 26;
    localparam int          LOW_W           = 16;
    localparam int          HIGH_W          = 10;
    localparam int          OE_BIT          = 10;
    localparam int          RANGE_W         = 4;
    localparam int          GAIN_W          = 20;
    localparam int          OFFSET_W        = FCW_W + GAIN_W;

    // ****************************************
    // Reset values and word limit codes
    // ****************************************
    localparam logic [15:0] FREQ_LOW_RST    = 16'h0000;
    localparam logic [9:0]  FREQ_HIGH_RST   = 10'h000;
    localparam logic        OE_BIT_RST      = 1'b0;
    localparam logic [3:0]  FACTORY_RANGE   = 4'h9;
    localparam logic [25:0] FCW_MOST_NEG    = 26'h2000000;
    localparam logic [25:0] FCW_LIMIT_NEG   = 26'h2000001;

    // ****************************************
    // Timing
    // ****************************************
    localparam int          CLK_HZ          = 50000000;
    localparam int          UPDATE_RATE_HZ  = 38000;
    localparam int          UPDATE_GAP_CYC  = (CLK_HZ + UPDATE_RATE_HZ - 1) / UPDATE_RATE_HZ;
    localparam int          GAP_CNT_W       = 11;
    localparam logic [1:0]  STRAP_WAIT      = 2'h2;

    // ****************************************
    // Apply sequencer states
    // ****************************************
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_APPLY = 3'b010,
        ST_HOLD  = 3'b100
    } apply_state_e;

endpackage

// File: hw/bit_sync.sv
// Two-stage synchroniser for a level arriving from a pin
`timescale 1ns/10ps
module bit_sync (
    input  wire logic clk_sys,
    input  wire logic nrst,
    input  wire logic async_in,
    output logic      sync_out
);
    logic meta_reg;

    // First stage is read only by the second
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            meta_reg <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule

// File: hw/pull_scaler.sv
// Limits the frequency word and scales it by the selected pull range
`timescale 1ns/10ps
module pull_scaler
    import pull_ctrl_pkg::*;
(
    input  wire logic [FCW_W-1:0]    fcw,
    input  wire logic [RANGE_W-1:0]  range_code,
    output logic [FCW_W-1:0]         fcw_limited,
    output logic signed [OFFSET_W-1:0] frac_offset
);
    // ****************************************
    // Range gain in hundredths of a ppm
    // ****************************************
    // RULE14: ascending range order
    // RULE10: LSB weight is range over full scale
    function automatic logic [GAIN_W-1:0] range_gain(input logic [RANGE_W-1:0] code);
        logic [GAIN_W-1:0] g;
        g = 20'h00271;
        case (code)
            4'h0: g = 20'h00271;
            4'h1: g = 20'h003E8;
            4'h2: g = 20'h004E2;
            4'h3: g = 20'h009C4;
            4'h4: g = 20'h01388;
            4'h5: g = 20'h01F40;
            4'h6: g = 20'h02710;
            4'h7: g = 20'h030D4;
            4'h8: g = 20'h03A98;
            4'h9: g = 20'h04E20;
            4'hA: g = 20'h09C40;
            4'hB: g = 20'h0EA60;
            4'hC: g = 20'h13880;
            4'hD: g = 20'h1D4C0;
            4'hE: g = 20'h27100;
            default: g = 20'h4E200;
        endcase
        return g;
    endfunction

    // RULE4: most negative code would overshoot
    always_comb begin
        if (fcw == FCW_MOST_NEG) begin
            fcw_limited = FCW_LIMIT_NEG;
        end else begin
            fcw_limited = fcw;
        end
    end

    // RULE9: divider offset linear in word
    always_comb begin
        frac_offset = OFFSET_W'($signed(fcw_limited) * $signed({1'b0, range_gain(range_code)}));
    end
endmodule

// File: sim/pull_host_model.sv
// Host model driving the strobe register port of the pull control block
`timescale 1ns/10ps
module pull_host_model
    import pull_ctrl_pkg::*;
(
    input  wire logic              clk_sys,
    output logic [ADDR_W-1:0]      reg_addr,
    output logic [DATA_W-1:0]      reg_wdata,
    output logic                   reg_wr,
    output logic                   reg_rd,
    input  wire logic [DATA_W-1:0] reg_rdata
);
    int cycle_cnt = 0;
    int last_high = -100000;

    initial begin
        reg_addr  = 8'h00;
        reg_wdata = 16'h0000;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end

    always @(posedge clk_sys) begin
        cycle_cnt <= cycle_cnt + 1;
    end

    task automatic write_reg(input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] data);
        @(posedge clk_sys);
        reg_addr  <= addr;
        reg_wdata <= data;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
        // Released lines carry the inverse so a late sample is caught
        reg_addr  <= ~addr;
        reg_wdata <= ~data;
        if (addr == REG_FREQ_HIGH) begin
            last_high = cycle_cnt;
        end
    endtask

    task automatic read_reg(input logic [ADDR_W-1:0] addr, output logic [DATA_W-1:0] data);
        @(posedge clk_sys);
        reg_addr <= addr;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        reg_addr <= ~addr;
        #1;
        data = reg_rdata;
    endtask

    function automatic logic [FCW_W-1:0] ctrl_word(input real ppm, input real range_ppm);
        return FCW_W'(longint'(ppm / range_ppm * 33554431.0));
    endfunction

    task automatic set_word(input logic [FCW_W-1:0] word, input logic oe);
        while (cycle_cnt - last_high < UPDATE_GAP_CYC + 4) begin
            @(posedge clk_sys);
        end
        write_reg(REG_FREQ_LOW, word[15:0]);
        write_reg(REG_FREQ_HIGH, {5'h00, oe, word[25:16]});
    endtask
endmodule

// File: sim/digital_frequency_pull_control_tb.sv
// Self-checking bench for the frequency pull register block
`timescale 1ns/10ps
`define CHK(a, e, m) begin checks++; if ((a) !== (e)) begin errors++; $display("[FAIL] %0t %s", $time, m); end end
module digital_frequency_pull_control_tb
    import pull_ctrl_pkg::*;
;
    // Whole run is about 29k cycles, dominated by the update gaps
    localparam int TIMEOUT_CYC = 40000;
    localparam int GAIN_TAB [16] = '{625, 1000, 1250, 2500, 5000, 8000, 10000, 12500,
                                     15000, 20000, 40000, 60000, 80000, 120000, 160000, 320000};
    logic                       clk_sys;
    logic                       nrst;
    logic [ADDR_W-1:0]          reg_addr;
    logic [DATA_W-1:0]          reg_wdata;
    logic                       reg_wr;
    logic                       reg_rd;
    logic [DATA_W-1:0]          reg_rdata;
    logic                       oe_pin;
    logic                       sw_oe_strap;
    logic [FCW_W-1:0]           fcw_applied;
    logic [RANGE_W-1:0]         range_applied;
    logic signed [OFFSET_W-1:0] frac_offset;
    logic                       freq_update;
    logic                       update_busy;
    logic                       out_enable;
    logic [DATA_W-1:0]          rd;
    logic [FCW_W-1:0]           w;
    int                         errors = 0;
    int                         checks = 0;
    int                         cycles = 0;
    int                         t0;

    freq_pull_ctrl dut (
        .clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .oe_pin(oe_pin),
        .sw_oe_strap(sw_oe_strap), .fcw_applied(fcw_applied), .range_applied(range_applied),
        .frac_offset(frac_offset), .freq_update(freq_update), .update_busy(update_busy),
        .out_enable(out_enable)
    );

    pull_host_model host (
        .clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata)
    );

    always #10 clk_sys = ~clk_sys;

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == TIMEOUT_CYC) begin
            errors++;
            $display("[FAIL] %0t timeout", $time);
            complete_run();
        end
    end

    function automatic logic signed [OFFSET_W-1:0] exp_off(input logic [FCW_W-1:0] x, input int r);
        longint v;
        v = longint'($signed(x)) * longint'(GAIN_TAB[r]);
        return OFFSET_W'(v);
    endfunction

    task automatic complete_run();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic do_reset(input logic strap);
        @(posedge clk_sys);
        nrst        <= 1'b0;
        sw_oe_strap <= strap;
        repeat (12) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (6) @(posedge clk_sys);
        #1;
        `CHK(fcw_applied, 26'h0000000, "reset word")
        `CHK(frac_offset, 46'sh0, "reset offset")
        `CHK(range_applied, FACTORY_RANGE, "factory range")
        `CHK(freq_update, 1'b0, "reset update pulse")
        `CHK(update_busy, 1'b0, "reset busy")
        `CHK(out_enable, 1'b0, "reset enable")
        host.read_reg(REG_FREQ_HIGH, rd);
        `CHK(rd, 16'h0000, "high reset")
        host.read_reg(REG_PULL_RANGE, rd);
        `CHK(rd, {12'h000, FACTORY_RANGE}, "range reset")
    endtask

    task automatic apply_chk(input logic [FCW_W-1:0] x, input logic [FCW_W-1:0] ex, input logic oe, input int r);
        host.set_word(x, oe);
        @(posedge clk_sys);
        #1;
        `CHK(freq_update, 1'b1, "no update pulse")
        `CHK(fcw_applied, ex, "applied word")
        `CHK(frac_offset, exp_off(ex, r), "divider offset")
        `CHK(out_enable, oe, "output enable")
        `CHK(update_busy, 1'b1, "busy in gap")
    endtask

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        clk_sys     = 1'b0;
        nrst        = 1'b0;
        oe_pin      = 1'b0;
        sw_oe_strap = 1'b0;
        do_reset(1'b0);
        host.write_reg(REG_FREQ_HIGH, 16'h0400);
        repeat (4) @(posedge clk_sys);
        #1;
        `CHK(out_enable, 1'b0, "oe bit under pin control")
        @(posedge clk_sys);
        oe_pin <= 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        `CHK(out_enable, 1'b0, "pin seen early")
        @(posedge clk_sys);
        #1;
        `CHK(out_enable, 1'b1, "pin not followed")
        $display("test pin_oe done");
        do_reset(1'b1);
        host.write_reg(REG_PULL_RANGE, 16'hFFFF);
        host.write_reg(8'h03, 16'hFFFF);
        host.read_reg(REG_PULL_RANGE, rd);
        `CHK(rd, 16'h000F, "range readback")
        `CHK(range_applied, 4'hF, "range in use")
        host.read_reg(8'h03, rd);
        `CHK(rd, 16'h0000, "unmapped read")
        host.write_reg(REG_FREQ_HIGH, 16'hFFFF);
        host.read_reg(REG_FREQ_HIGH, rd);
        `CHK(rd, 16'h07FF, "high readback")
        host.read_reg(REG_FREQ_LOW, rd);
        `CHK(rd, 16'h0000, "low disturbed")
        $display("test reg_map done");
        host.write_reg(REG_PULL_RANGE, 16'h0009);
        w = host.ctrl_word(90.0, 200.0);
        `CHK(w, 26'h0E66666, "host word")
        host.write_reg(REG_FREQ_LOW, w[15:0]);
        repeat (20) @(posedge clk_sys);
        #1;
        `CHK(fcw_applied, 26'h3FF0000, "low applied alone")
        apply_chk(w, w, 1'b1, 9);
        apply_chk(host.ctrl_word(-50.0, 200.0), 26'h3800000, 1'b0, 9);
        $display("test word_order done");
        for (int r = 0; r < 16; r++) begin
            host.write_reg(REG_PULL_RANGE, 16'(r));
            repeat (2) @(posedge clk_sys);
            #1;
            `CHK(range_applied, 4'(r), "range code")
            w = r[0] ? 26'h3543210 : 26'h0ABCDEF;
            apply_chk(w, w, 1'b1, r);
        end
        $display("test range_sweep done");
        apply_chk(26'h2000000, FCW_LIMIT_NEG, 1'b1, 15);
        apply_chk(26'h1FFFFFF, 26'h1FFFFFF, 1'b1, 15);
        $display("test limit done");
        t0 = cycles;
        host.write_reg(REG_FREQ_HIGH, 16'h0555);
        host.write_reg(REG_FREQ_HIGH, 16'h06AA);
        #1;
        while (freq_update !== 1'b1 && cycles - t0 < 2000) begin
            @(posedge clk_sys);
            #1;
        end
        `CHK(cycles - t0 inside {[UPDATE_GAP_CYC - 2 : UPDATE_GAP_CYC + 4]}, 1'b1, "update spacing")
        `CHK(fcw_applied, 26'h2AAFFFF, "latest word")
        repeat (UPDATE_GAP_CYC - 4) @(posedge clk_sys);
        #1;
        `CHK(update_busy, 1'b1, "busy ended early")
        repeat (6) @(posedge clk_sys);
        #1;
        `CHK(update_busy, 1'b0, "busy after gap")
        $display("test rate_limit done");
        complete_run();
    end
endmodule
